// ==== bench/scss_ctl_model.sv ====
// Purpose: Motion controller model that issues commands over the register bus
// Assumes: Classic Wishbone single cycles, one request at a time
// Notes: Waits for ack with no assumed latency; released data is inverted
`timescale 1ns/1ps
module scss_ctl_model (
  input wire logic clk_i,
  input wire logic wb_ack_i,
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [7:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o
);
  initial
  begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0000_0000;
  end
  // Fields for the command travel as plain register writes
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
  begin
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= adr;
    wb_sel_o <= 4'hF;
    wb_dat_o <= dat;
    // Hold until the answer comes
    do @(posedge clk_i); while (wb_ack_i !== 1'b1);
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o <= 1'b0;
    wb_dat_o <= ~dat;
    @(posedge clk_i);
  end
  endtask
endmodule

// ==== bench/tb.sv ====
// Purpose: Self-checking bench for the speed control soft start block
// Assumes: Short ramp tick of 20 cycles
// Notes: Reads are checked from a queue by a monitor on ack
`timescale 1ns/1ps
module tb
  import scss_pkg::*;
();
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack, irq, pext, next;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, rnd;
  logic signed [31:0] speed;
  logic [24:0] cr1o, cr2o;
  logic [9:0] tlp, tln;
  logic [31:0] exp_q[$], msk_q[$];
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  always #2.5 clk_i = ~clk_i;
  scss_ctl_model u_ctl (.clk_i(clk_i), .wb_ack_i(ack), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
    .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat));
  scss_top #(.TICK_CYCLES(20)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pos_ext_limit_i(pext), .neg_ext_limit_i(next), .speed_cmd_o(speed), .creep_first_o(cr1o),
    .creep_second_o(cr2o), .trq_lim_pos_o(tlp), .trq_lim_neg_o(tln), .irq_o(irq));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tally_and_finish();
    if (fails == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_ctl.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
  begin
    exp_q.push_back(e);
    msk_q.push_back(m);
    u_ctl.xfer(1'b0, a, 32'h0000_0000);
  end
  endtask
  task automatic see(input logic [31:0] v, input logic [31:0] e);
  begin
    compares++;
    if (v !== e)
    begin
      fails++;
      $display("Error %0t output %h expected %h", $time, v, e);
    end
  end
  endtask
  task automatic wait_speed(input logic [31:0] e, input int lim);
  begin
    for (int i = 0; i < lim && speed !== e; i++)
      @(posedge clk_i);
    see(speed, e);
  end
  endtask
  always @(posedge clk_i)
  begin
    if (ack === 1'b1 && we === 1'b0)
    begin
      compares++;
      if ((rdat & msk_q[0]) !== (exp_q[0] & msk_q[0]))
      begin
        fails++;
        $display("Error %0t read %h expected %h", $time, rdat, exp_q[0]);
      end
      exp_q.delete(0);
      msk_q.delete(0);
    end
  end
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fails++;
      tally_and_finish();
    end
  end
  localparam logic [9:0] MEXP[5] = '{10'h320, 10'h064, 10'h12C, 10'h12C, 10'h064};
  initial
  begin
    pext = 1'b0;
    next = 1'b0;
    rnd = 32'ha3be_3231;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_CR1, 32'h0000_0032, '1);
    rd(OFS_CR2, 32'h0000_0005, '1);
    rd(OFS_CR2X, 32'h0000_0000, '1);
    rd(OFS_ACCT, 32'h0000_0000, '1);
    rd(OFS_DECT, 32'h0000_0000, '1);
    rd(OFS_METH, 32'h0000_0000, '1);
    rd(OFS_TLA, 32'h0320_0320, '1);
    rd(8'hFC, 32'h0000_0000, '1);
    see(tlp, 32'h0000_0320);
    // Servo off: command refused with condition warning and interrupt
    wr(OFS_VREF, 32'h0000_0064);
    wr(OFS_CMD, 32'h0000_0001);
    rd(OFS_CMD, {30'h0, RES_COND}, 32'h0000_0003);
    rd(OFS_STAT, 32'h0000_0004, 32'h0000_0004);
    see(speed, 32'h0000_0000);
    wr(OFS_MASK, 32'h0000_0004);
    see(irq, 32'h0000_0001);
    wr(OFS_STAT, 32'h0000_0004);
    see(irq, 32'h0000_0000);
    for (int i = 0; i < 2; i++)
    begin
      wr(OFS_CR1X + 8'(8 * i), 32'h0000_04D2);
      see({7'h0, i == 0 ? cr1o : cr2o}, i == 0 ? 32'h0000_0032 : 32'h0000_0005);
      wr(OFS_CR1 + 8'(8 * i), 32'h0000_0000);
      repeat (2) @(posedge clk_i);
      see({7'h0, i == 0 ? cr1o : cr2o}, 32'h0000_04D2);
    end
    wr(OFS_CR1X, 32'hFFFF_FFFF);
    rd(OFS_CR1X, CRX_MAX, '1);
    wr(OFS_ACCT, 32'h0000_FFFF);
    rd(OFS_ACCT, TIME_MAX, '1);
    // Ramp up at 10 units per tick, then step down with zero decel time
    wr(OFS_CTRL, 32'h0000_0001);
    wr(OFS_ACCT, 32'h0000_03E8);
    wr(OFS_CMD, 32'h0000_0001);
    rd(OFS_CMD, {30'h0, RES_OK}, 32'h0000_0003);
    repeat (60) @(posedge clk_i);
    see({31'h0, speed > 0 && speed < 100}, 32'h0000_0001);
    wait_speed(32'h0000_0064, 400);
    rd(OFS_STAT, 32'h0000_0010, 32'h0000_0010);
    wr(OFS_VREF, 32'h0000_0000);
    wr(OFS_CMD, 32'h0000_0001);
    wait_speed(32'h0000_0000, 6);
    // Fields with zero accel override the register time
    wr(OFS_ACCF, 32'h0000_0000);
    wr(OFS_DECF, 32'h0000_03E8);
    wr(OFS_VREF, 32'hFFFF_FFC4);
    wr(OFS_CMD, 32'h0000_0003);
    wait_speed(32'hFFFF_FFC4, 6);
    wr(OFS_VREF, 32'h0000_0000);
    wr(OFS_CMD, 32'h0000_0003);
    repeat (6) @(posedge clk_i);
    see({31'h0, speed < 0}, 32'h0000_0001);
    wait_speed(32'h0000_0000, 300);
    wr(OFS_DECF, 32'h0000_0000);
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      wr(OFS_PLW, rnd);
      rd(OFS_PLW, rnd, '1);
      wr(OFS_NLW, ~rnd);
      rd(OFS_NLW, ~rnd, '1);
      wr(OFS_HOME, rnd ^ 32'h5A5A_5A5A);
      rd(OFS_HOME, rnd ^ 32'h5A5A_5A5A, '1);
      wr(OFS_VREF, {{21{rnd[10]}}, rnd[10:0]});
      wr(OFS_CMD, 32'h0000_0003);
      wait_speed({{21{rnd[10]}}, rnd[10:0]}, 6);
    end
    // Field time out of range is refused with a range warning
    wr(OFS_ACCF, 32'h0000_2711);
    wr(OFS_CMD, 32'h0000_0003);
    rd(OFS_CMD, {30'h0, RES_RANGE}, 32'h0000_0003);
    rd(OFS_STAT, 32'h0000_0008, 32'h0000_0008);
    // Torque limit source per method, external gates high
    wr(OFS_TLIMF, 32'h0000_012C);
    wr(OFS_CMD, 32'h0000_0001);
    pext <= 1'b1;
    next <= 1'b1;
    for (int m = 0; m < 5; m++)
    begin
      wr(OFS_METH, 32'(m));
      repeat (4) @(posedge clk_i);
      see({22'h0, tlp}, {22'h0, MEXP[m]});
      see({22'h0, tln}, {22'h0, MEXP[m]});
    end
    pext <= 1'b0;
    next <= 1'b0;
    wr(OFS_METH, 32'h0000_0001);
    repeat (5) @(posedge clk_i);
    see({22'h0, tlp}, 32'h0000_0320);
    wr(OFS_METH, 32'h0000_0005);
    rd(OFS_METH, 32'h0000_0000, '1);
    // Command torque limit above range is clamped and flagged
    wr(OFS_TLIMF, 32'h0000_03E8);
    wr(OFS_METH, 32'h0000_0002);
    wr(OFS_CMD, 32'h0000_0001);
    rd(OFS_STAT, 32'h0000_0002, 32'h0000_0002);
    repeat (2) @(posedge clk_i);
    see({22'h0, tlp}, 32'h0000_0320);
    repeat (2) @(posedge clk_i);
    tally_and_finish();
  end
endmodule

// ==== rtl/scss_pkg.sv ====
// Purpose: Constants for the speed control soft start block
// Assumes: 200 MHz clock, 32-bit classic Wishbone register bus
// Notes: Byte offsets, defaults, limits and status bit positions

package scss_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_VREF = 8'h08;
  localparam logic [7:0] OFS_ACCF = 8'h0C;
  localparam logic [7:0] OFS_DECF = 8'h10;
  localparam logic [7:0] OFS_TLIMF = 8'h14;
  localparam logic [7:0] OFS_ACCT = 8'h18;
  localparam logic [7:0] OFS_DECT = 8'h1C;
  localparam logic [7:0] OFS_CR1 = 8'h20;
  localparam logic [7:0] OFS_CR1X = 8'h24;
  localparam logic [7:0] OFS_CR2 = 8'h28;
  localparam logic [7:0] OFS_CR2X = 8'h2C;
  localparam logic [7:0] OFS_METH = 8'h30;
  localparam logic [7:0] OFS_TLA = 8'h34;
  localparam logic [7:0] OFS_TLB = 8'h38;
  localparam logic [7:0] OFS_SPD = 8'h3C;
  localparam logic [7:0] OFS_STAT = 8'h40;
  localparam logic [7:0] OFS_MASK = 8'h44;
  localparam logic [7:0] OFS_HOME = 8'h48;
  localparam logic [7:0] OFS_PLW = 8'h4C;
  localparam logic [7:0] OFS_NLW = 8'h50;
  // Command word bits
  localparam int CMD_GO_B = 0;
  localparam int CMD_FLD_B = 1;
  // Status bits: accepted, clamp, condition, range, target reached
  localparam int ST_ACC_B = 0;
  localparam int ST_CLAMP_B = 1;
  localparam int ST_COND_B = 2;
  localparam int ST_RANGE_B = 3;
  localparam int ST_REACH_B = 4;
  // Command result codes
  localparam logic [1:0] RES_OK = 2'h1;
  localparam logic [1:0] RES_COND = 2'h2;
  localparam logic [1:0] RES_RANGE = 2'h3;
  // Defaults and limits
  localparam logic [15:0] CR1_DEF = 16'h0032;
  localparam logic [15:0] CR2_DEF = 16'h0005;
  localparam logic [31:0] CRX_MAX = 32'h0140_0000;
  localparam logic [31:0] TIME_MAX = 32'h0000_2710;
  localparam logic [31:0] TRQ_MAX = 32'h0000_0320;
  localparam logic [9:0] TLA_DEF = 10'h320;
  localparam logic [9:0] TLB_DEF = 10'h064;
  localparam logic [31:0] MAX_SPEED = 32'h0000_2710;
  localparam int TLN_POS = 16;
  // Ramp tick of one millisecond
  localparam int TICK_NS = 1000000;
  localparam int CLK_NS = 5;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  // Ramp states
  typedef enum logic [2:0] {
    RS_IDLE = 3'b001,
    RS_ACC = 3'b010,
    RS_DEC = 3'b100
  } scss_rs_t;
endpackage

// ==== rtl/scss_top.sv ====
// Purpose: Speed control command handler with soft start ramp
// Assumes: Single clock, synchronous reset, classic Wishbone slave
// Notes: All state is one struct registered in one process
//
// Our own choices: the Wishbone interface to the registers and the register offsets.

`timescale 1ns/1ps

module scss_top
  import scss_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pos_ext_limit_i,
  input wire logic neg_ext_limit_i,
  output logic signed [31:0] speed_cmd_o,
  output logic [24:0] creep_first_o,
  output logic [24:0] creep_second_o,
  output logic [9:0] trq_lim_pos_o,
  output logic [9:0] trq_lim_neg_o,
  output logic irq_o
);

  typedef struct packed {
    logic [2:0] pl_s;
    logic [2:0] nl_s;
    logic p_lim;
    logic n_lim;
    logic ack;
    logic [31:0] rdat;
    logic servo_on;
    logic [31:0] vref;
    logic [31:0] tgt;
    logic [31:0] spd;
    logic [15:0] acc_f;
    logic [15:0] dec_f;
    logic [15:0] command_torque_limit_f;
    logic [15:0] acc_t;
    logic [15:0] dec_t;
    logic [15:0] act_acc;
    logic [15:0] act_dec;
    logic [15:0] cr1;
    logic [15:0] cr2;
    logic [24:0] cr1x;
    logic [24:0] cr2x;
    logic [31:0] home;
    logic [31:0] plw;
    logic [31:0] nlw;
    logic [2:0] meth;
    logic [9:0] tap;
    logic [9:0] tan;
    logic [9:0] tbp;
    logic [9:0] tbn;
    logic [9:0] tcmd;
    logic [31:0] tick;
    logic [31:0] acc;
    logic [1:0] resp;
    logic [4:0] stat;
    logic [4:0] mask;
    logic irq;
    logic [24:0] c1o;
    logic [24:0] c2o;
    logic [9:0] tpo;
    logic [9:0] tno;
    scss_rs_t st;
  } scss_state_t;

  scss_state_t q_q;
  scss_state_t q_d;

  function automatic logic [31:0] wmask(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
      begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] sat(input logic [31:0] v, input logic [31:0] mx);
    return (v > mx) ? mx : v;
  endfunction

  function automatic logic [9:0] mn(input logic [9:0] a, input logic [9:0] b);
    return (a < b) ? a : b;
  endfunction

  // Effective limit of one direction from the chosen sources
  function automatic logic [9:0] tsel(input logic [2:0] m, input logic [9:0] a, input logic [9:0] b,
                                      input logic [9:0] c, input logic ext);
    logic [9:0] r;
    r = a;
    case (m)
      3'h1: r = ext ? mn(a, b) : a;
      3'h2: r = mn(a, c);
      3'h3: r = ext ? mn(a, c) : a;
      3'h4: r = ext ? mn(a, mn(b, c)) : a;
      default: r = a;
    endcase
    return r;
  endfunction

  // True while the speed magnitude moves away from zero
  function automatic logic ramp_up(input logic [31:0] s, input logic [31:0] t);
    logic up;
    up = $signed(t) > $signed(s);
    return (s == 32'h0000_0000) || (up == ($signed(s) > 0));
  endfunction

  logic [31:0] rv;
  logic [31:0] wv;
  logic [31:0] a_n;
  logic [15:0] t_act;
  logic [15:0] f_acc;
  logic [15:0] f_dec;
  logic [4:0] set;
  logic req;
  scss_rs_t ph;

  always_comb
  begin
    q_d = q_q;
    q_d.ack = 1'b0;
    set = 5'h00;
    rv = 32'h0000_0000;
    wv = 32'h0000_0000;
    a_n = 32'h0000_0000;
    t_act = 16'h0000;
    f_acc = 16'h0000;
    f_dec = 16'h0000;
    ph = RS_IDLE;
    // Limit inputs: three stages, accept once the last two agree
    q_d.pl_s = {q_q.pl_s[1:0], pos_ext_limit_i};
    q_d.nl_s = {q_q.nl_s[1:0], neg_ext_limit_i};
    if (q_q.pl_s[1] == q_q.pl_s[2])
    begin
      q_d.p_lim = q_q.pl_s[2];
    end
    if (q_q.nl_s[1] == q_q.nl_s[2])
    begin
      q_d.n_lim = q_q.nl_s[2];
    end
    q_d.tick = (q_q.tick >= 32'(TICK_CYCLES - 1)) ? 32'h0000_0000 : q_q.tick + 32'h0000_0001;

    case (wb_adr_i)
      OFS_CTRL: rv = {31'h0, q_q.servo_on};
      OFS_CMD: rv = {30'h0, q_q.resp};
      OFS_VREF: rv = q_q.vref;
      OFS_ACCF: rv = {16'h0, q_q.acc_f};
      OFS_DECF: rv = {16'h0, q_q.dec_f};
      OFS_TLIMF: rv = {16'h0, q_q.command_torque_limit_f};
      OFS_ACCT: rv = {16'h0, q_q.acc_t};
      OFS_DECT: rv = {16'h0, q_q.dec_t};
      OFS_CR1: rv = {16'h0, q_q.cr1};
      OFS_CR1X: rv = {7'h0, q_q.cr1x};
      OFS_CR2: rv = {16'h0, q_q.cr2};
      OFS_CR2X: rv = {7'h0, q_q.cr2x};
      OFS_METH: rv = {29'h0, q_q.meth};
      OFS_TLA: rv = {6'h0, q_q.tan, 6'h0, q_q.tap};
      OFS_TLB: rv = {6'h0, q_q.tbn, 6'h0, q_q.tbp};
      OFS_SPD: rv = q_q.spd;
      OFS_STAT: rv = {27'h0, q_q.stat};
      OFS_MASK: rv = {27'h0, q_q.mask};
      OFS_HOME: rv = q_q.home;
      OFS_PLW: rv = q_q.plw;
      OFS_NLW: rv = q_q.nlw;
      default: rv = 32'h0000_0000;
    endcase
    wv = wmask(rv, wb_dat_i, wb_sel_i);

    req = wb_cyc_i & wb_stb_i & ~q_q.ack;
    if (req)
    begin
      q_d.ack = 1'b1;
      q_d.rdat = rv;
    end
    if (req && wb_we_i)
    begin
      case (wb_adr_i)
        OFS_CTRL: q_d.servo_on = wv[0];
        OFS_VREF: q_d.vref = wv;
        OFS_ACCF: q_d.acc_f = wv[15:0];
        OFS_DECF: q_d.dec_f = wv[15:0];
        OFS_TLIMF: q_d.command_torque_limit_f = wv[15:0];
        OFS_ACCT: q_d.acc_t = 16'(sat(wv, TIME_MAX));
        OFS_DECT: q_d.dec_t = 16'(sat(wv, TIME_MAX));
        OFS_CR1: q_d.cr1 = wv[15:0];
        OFS_CR1X: q_d.cr1x = 25'(sat(wv, CRX_MAX));
        OFS_CR2: q_d.cr2 = wv[15:0];
        OFS_CR2X: q_d.cr2x = 25'(sat(wv, CRX_MAX));
        OFS_METH: q_d.meth = (wv[2:0] > 3'h4) ? 3'h0 : wv[2:0];
        OFS_TLA:
        begin
          q_d.tap = 10'(sat({22'h0, wv[9:0]}, TRQ_MAX));
          q_d.tan = 10'(sat({22'h0, wv[TLN_POS +: 10]}, TRQ_MAX));
        end
        OFS_TLB:
        begin
          q_d.tbp = 10'(sat({22'h0, wv[9:0]}, TRQ_MAX));
          q_d.tbn = 10'(sat({22'h0, wv[TLN_POS +: 10]}, TRQ_MAX));
        end
        OFS_MASK: q_d.mask = wv[4:0];
        OFS_HOME: q_d.home = wv;
        OFS_PLW: q_d.plw = wv;
        OFS_NLW: q_d.nlw = wv;
        OFS_CMD:
        begin
          if (wv[CMD_GO_B])
          begin
            f_acc = wv[CMD_FLD_B] ? q_q.acc_f : q_q.acc_t;
            f_dec = wv[CMD_FLD_B] ? q_q.dec_f : q_q.dec_t;
            if (!q_q.servo_on)
            begin
              set[ST_COND_B] = 1'b1;
              q_d.resp = RES_COND;
            end
            else if ({16'h0, f_acc} > TIME_MAX || {16'h0, f_dec} > TIME_MAX)
            begin
              set[ST_RANGE_B] = 1'b1;
              q_d.resp = RES_RANGE;
            end
            else
            begin
              set[ST_ACC_B] = 1'b1;
              q_d.resp = RES_OK;
              q_d.tgt = q_q.vref;
              q_d.act_acc = f_acc;
              q_d.act_dec = f_dec;
              q_d.tcmd = 10'(sat({16'h0, q_q.command_torque_limit_f}, TRQ_MAX));
              set[ST_CLAMP_B] = ({16'h0, q_q.command_torque_limit_f} > TRQ_MAX);
            end
          end
        end
        default: q_d.servo_on = q_q.servo_on;
      endcase
    end

    // Soft start ramp
    ph = ramp_up(q_q.spd, q_q.tgt) ? RS_ACC : RS_DEC;
    case (q_q.st)
      RS_IDLE:
      begin
        if (q_q.spd != q_q.tgt)
        begin
          q_d.st = ph;
          q_d.acc = 32'h0000_0000;
        end
      end
      RS_ACC, RS_DEC:
      begin
        q_d.st = ph;
        t_act = (q_q.st == RS_ACC) ? q_q.act_acc : q_q.act_dec;
        if (q_q.spd == q_q.tgt)
        begin
          q_d.st = RS_IDLE;
          set[ST_REACH_B] = 1'b1;
        end
        else if (t_act == 16'h0000)
        begin
          q_d.spd = q_q.tgt;
        end
        else
        begin
          // Max speed added per ms, drained by the time per unit step
          a_n = q_q.acc + ((q_q.tick == 32'h0000_0000) ? MAX_SPEED : 32'h0000_0000);
          if (a_n >= {16'h0, t_act})
          begin
            a_n = a_n - {16'h0, t_act};
            if ($signed(q_q.tgt) > $signed(q_q.spd))
            begin
              q_d.spd = q_q.spd + 32'h0000_0001;
            end
            else
            begin
              q_d.spd = q_q.spd - 32'h0000_0001;
            end
          end
          q_d.acc = a_n;
        end
      end
      default: q_d.st = RS_IDLE;
    endcase
    if (!q_q.servo_on)
    begin
      q_d.tgt = 32'h0000_0000;
      q_d.spd = 32'h0000_0000;
      q_d.st = RS_IDLE;
    end

    // Sticky status: a new event wins over a clearing write
    if (req && wb_we_i && wb_adr_i == OFS_STAT)
    begin
      q_d.stat = q_q.stat & ~wv[4:0];
    end
    q_d.stat = q_d.stat | set;
    q_d.irq = |(q_d.stat & q_d.mask);

    q_d.c1o = (q_q.cr1 == 16'h0000) ? q_q.cr1x : {9'h0, q_q.cr1};
    q_d.c2o = (q_q.cr2 == 16'h0000) ? q_q.cr2x : {9'h0, q_q.cr2};
    q_d.tpo = tsel(q_q.meth, q_q.tap, q_q.tbp, q_q.tcmd, q_q.p_lim);
    q_d.tno = tsel(q_q.meth, q_q.tan, q_q.tbn, q_q.tcmd, q_q.n_lim);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q_q <= '0;
      q_q.cr1 <= CR1_DEF;
      q_q.cr2 <= CR2_DEF;
      q_q.tap <= TLA_DEF;
      q_q.tan <= TLA_DEF;
      q_q.tbp <= TLB_DEF;
      q_q.tbn <= TLB_DEF;
      q_q.tcmd <= TLA_DEF;
      q_q.tpo <= TLA_DEF;
      q_q.tno <= TLA_DEF;
      q_q.c1o <= {9'h000, CR1_DEF};
      q_q.c2o <= {9'h000, CR2_DEF};
      q_q.st <= RS_IDLE;
    end
    else
    begin
      q_q <= q_d;
    end
  end

  assign wb_dat_o = q_q.rdat;
  assign wb_ack_o = q_q.ack;
  assign speed_cmd_o = q_q.spd;
  assign creep_first_o = q_q.c1o;
  assign creep_second_o = q_q.c2o;
  assign trq_lim_pos_o = q_q.tpo;
  assign trq_lim_neg_o = q_q.tno;
  assign irq_o = q_q.irq;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_cmd_go;
    wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == OFS_CMD && wb_sel_i[0] && wb_dat_i[CMD_GO_B];
  endsequence

  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  AST_ACK_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  AST_CREEP1: assert property (##1 creep_first_o == (($past(q_q.cr1) == 16'h0000) ? $past(q_q.cr1x)
                                                  : {9'h0, $past(q_q.cr1)}))
    else $error("first creep speed source wrong");
  AST_CREEP2: assert property (##1 creep_second_o == (($past(q_q.cr2) == 16'h0000) ? $past(q_q.cr2x)
                                                   : {9'h0, $past(q_q.cr2)}))
    else $error("second creep speed source wrong");
  AST_OFF_IGNORE: assert property (s_cmd_go ##0 !q_q.servo_on |=> q_q.stat[ST_COND_B] && q_q.tgt == 32'h0000_0000)
    else $error("command during servo off not refused");
  AST_CLAMP: assert property (s_cmd_go ##0 q_q.servo_on && {16'h0, q_q.command_torque_limit_f} > TRQ_MAX
                              && {16'h0, q_q.acc_t} <= TIME_MAX && !wb_dat_i[CMD_FLD_B]
                              |=> q_q.stat[ST_CLAMP_B] && q_q.tcmd == TRQ_MAX[9:0])
    else $error("torque limit not clamped");
  AST_ZERO_TIME: assert property (q_q.st == RS_ACC && q_q.act_acc == 16'h0000 && q_q.servo_on
                                  && q_q.spd != q_q.tgt |=> speed_cmd_o == $past(q_q.tgt))
    else $error("zero ramp time did not step");
  AST_SLOPE: assert property (q_q.st != RS_IDLE && q_q.servo_on && q_q.act_acc != 16'h0000
                              && q_q.act_dec != 16'h0000 |=> (speed_cmd_o - $past(speed_cmd_o) == 32'h0000_0001)
                              || ($past(speed_cmd_o) - speed_cmd_o == 32'h0000_0001)
                              || speed_cmd_o == $past(speed_cmd_o))
    else $error("ramp stepped by more than one unit");
  AST_PHASE: assert property (q_q.st == RS_ACC && q_q.spd != q_q.tgt |-> ramp_up(q_q.spd, q_q.tgt)
                              || $past(q_q.st) == RS_IDLE || $past(q_q.tgt) != q_q.tgt
                              || $past(q_q.spd) != q_q.spd)
    else $error("accel phase while magnitude falls");
  AST_IRQ: assert property (##1 irq_o == |($past(q_d.stat) & $past(q_d.mask)))
    else $error("interrupt output disagrees with status");

endmodule
